/* File: pkg/bsaeu_pkg.sv */
// Constants and types shared by the bit, accumulator and string executor
package bsaeu_pkg;
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_ACC = 8'h08;
  localparam logic [7:0] REG_CNT = 8'h0C;
  localparam logic [7:0] REG_FLAGS = 8'h10;
  localparam logic [7:0] REG_STAT = 8'h14;
  localparam logic [7:0] REG_LEN = 8'h18;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_BIT_LSB = 5;
  localparam int CMD_IO_BIT = 8;
  localparam int STAT_BUSY = 0;
  localparam int STAT_TAKEN = 1;
  localparam int STAT_MATCH = 2;
  localparam logic [31:0] ACC_RST = 32'h0000_0000;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [19:0] CYC_BIT_LOAD = 20'h3;
  localparam logic [19:0] CYC_BIT_RMW = 20'h4;
  localparam logic [19:0] CYC_BR_TAKEN = 20'h5;
  localparam logic [19:0] CYC_BR_NOT = 20'h4;
  localparam logic [19:0] CYC_TAS_TAKEN = 20'h7;
  localparam logic [19:0] CYC_TAS_NOT = 20'h6;
  localparam logic [19:0] CYC_WAIT_MIN = 20'h1;
  localparam logic [19:0] CYC_BYTE_SWAP = 20'h3;
  localparam logic [19:0] CYC_HALF_XCHG = 20'h2;
  localparam logic [19:0] CYC_EXT_BYTE = 20'h1;
  localparam logic [19:0] CYC_EXT_WORD = 20'h2;
  localparam logic [19:0] CYC_STR_BASE = 20'h2;
  localparam logic [19:0] CYC_STR_ELEM = 20'h6;
  localparam logic [19:0] CYC_MOVE_ZERO = 20'h4;
  localparam logic [19:0] CYC_SRCH_ZERO = 20'h3;
  localparam logic [19:0] CYC_MATCH_EXTRA = 20'h2;
  localparam logic [19:0] CYC_FILL_BASE = 20'h3;
  localparam logic [19:0] CYC_FILL_ELEM = 20'h5;
  typedef enum logic [4:0] {
    OP_BIT_MOVE, OP_BIT_FORCE_ONE, OP_BIT_FORCE_ZERO, OP_BRANCH_ON_BIT_CLEAR,
    OP_BRANCH_ON_BIT_SET, OP_TEST_AND_SET_BRANCH, OP_WAIT_IO_BIT_HIGH,
    OP_WAIT_IO_BIT_LOW, OP_BYTE_SWAP, OP_HALF_EXCHANGE, OP_BYTE_SIGN_EXTEND,
    OP_WORD_SIGN_EXTEND, OP_BYTE_ZERO_FILL, OP_WORD_ZERO_FILL, OP_BYTE_BLOCK_COPY,
    OP_BYTE_BLOCK_COPY_DOWN, OP_WORD_BLOCK_COPY, OP_WORD_BLOCK_COPY_DOWN,
    OP_BYTE_BLOCK_SEARCH, OP_BYTE_BLOCK_SEARCH_DOWN, OP_WORD_BLOCK_SEARCH,
    OP_WORD_BLOCK_SEARCH_DOWN, OP_BYTE_BLOCK_FILL, OP_WORD_BLOCK_FILL
  } bsaeu_op_e;
  localparam logic [4:0] OP_LAST = 5'h17;
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE, ST_PAD} bsaeu_state_e;
  typedef struct packed {
    logic io;
    logic we;
    logic word;
    logic [15:0] addr;
    logic [15:0] wdata;
  } bsaeu_mem_s;
  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } bsaeu_flags_s;
endpackage

/* File: verilog/bsaeu_core.sv */
// Executor for bit, accumulator and string instructions behind an APB register file
// Summary of operation
// - Bit load: bit to A, flags, 3 cycles
// - Set bit via read-modify-write, 4 cycles
// - Clear bit via read-modify-write, 4 cycles
// - Branch-if-clear taken on zero bit, sets Z
// - Branch-if-set taken on one bit, sets Z
// - Bit branches: 5 taken, 4 not
// - Test-and-set: branch on one, write one
// - Wait re-reads I/O bit until one
// - Wait re-reads I/O bit until zero
// - Byte swap of low word, 3 cycles
// - Exchange accumulator halves in 2 cycles
// - Sign extension byte/word, N and Z
// - Zero extension, N cleared, Z updated
// - Down byte copy decrements both pointers
// - Up word copy increments both pointers
// - Moves: 4 if count zero, else 2+6n
// - Word search compares against low half, NZVC
// - Searches: 3, 2+6n, or 6n+4 on match
// - Fill writes low half, 5m+3, N Z
//
// The register addresses and the APB slave port are this design's own decisions.
module bsaeu_core
  import bsaeu_pkg::*;
(
  input wire logic pclk, // Core clock, 40 MHz
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  output logic mem_req, // Memory access request
  output bsaeu_mem_s mem_cmd, // Memory access fields
  input wire logic mem_ack, // Memory access done
  input wire logic [15:0] mem_rdata, // Memory read data
  output logic exec_busy, // Instruction running
  output logic exec_done, // Final cycle of instruction
  output logic branch_taken // Outcome of last branch
);
  bsaeu_state_e state;
  bsaeu_state_e start_state;
  bsaeu_state_e elem_state;
  bsaeu_op_e cur_op;
  bsaeu_op_e new_op;
  bsaeu_op_e sel_op;
  bsaeu_flags_s flags;
  bsaeu_mem_s start_cmd;
  bsaeu_mem_s elem_cmd;
  logic [2:0] bit_pos;
  logic io_sel;
  logic [15:0] addr;
  logic [31:0] acc;
  logic [31:0] next_acc_op;
  logic [15:0] cnt;
  logic [15:0] start_cnt;
  logic [19:0] elapsed;
  logic [19:0] budget;
  logic [19:0] start_budget;
  logic [19:0] elem_cyc;
  logic [19:0] last_len;
  logic matched;
  logic apb_setup;
  logic apb_wr;
  logic cmd_legal;
  logic start;
  logic idle;
  logic rd_done;
  logic wr_done;
  logic pad_end;
  logic more;
  logic finish;
  logic elem_done;
  logic rd_bit;
  logic want;
  logic is_copy;
  logic is_search;
  logic is_fill;
  logic is_str;
  logic is_word;
  logic is_down;
  logic is_wait;
  logic is_rmw;
  logic [7:0] mod_byte;
  logic [15:0] step;
  logic [15:0] cmp_a;
  logic [15:0] cmp_b;
  logic [16:0] diff;
  logic cmp_eq;
  logic [31:0] rd_mux;
  logic rd_bad;

  assign idle = state == ST_IDLE;
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite;
  assign new_op = bsaeu_op_e'(pwdata[CMD_OP_LSB +: 5]);
  assign cmd_legal = pwdata[CMD_OP_LSB +: 5] <= OP_LAST;
  assign start = apb_wr && paddr == REG_CMD && idle && cmd_legal;
  // Class decode follows the incoming command while idle so start logic can share it
  assign sel_op = idle ? new_op : cur_op;
  assign is_copy = sel_op inside {OP_BYTE_BLOCK_COPY, OP_BYTE_BLOCK_COPY_DOWN,
                                  OP_WORD_BLOCK_COPY, OP_WORD_BLOCK_COPY_DOWN};
  assign is_search = sel_op inside {OP_BYTE_BLOCK_SEARCH, OP_BYTE_BLOCK_SEARCH_DOWN,
                                    OP_WORD_BLOCK_SEARCH, OP_WORD_BLOCK_SEARCH_DOWN};
  assign is_fill = sel_op inside {OP_BYTE_BLOCK_FILL, OP_WORD_BLOCK_FILL};
  assign is_str = is_copy || is_search || is_fill;
  assign is_word = sel_op inside {OP_WORD_BLOCK_COPY, OP_WORD_BLOCK_COPY_DOWN,
                                  OP_WORD_BLOCK_SEARCH, OP_WORD_BLOCK_SEARCH_DOWN,
                                  OP_WORD_BLOCK_FILL};
  assign is_down = sel_op inside {OP_BYTE_BLOCK_COPY_DOWN, OP_WORD_BLOCK_COPY_DOWN,
                                  OP_BYTE_BLOCK_SEARCH_DOWN, OP_WORD_BLOCK_SEARCH_DOWN};
  assign is_wait = sel_op inside {OP_WAIT_IO_BIT_HIGH, OP_WAIT_IO_BIT_LOW};
  assign is_rmw = sel_op inside {OP_BIT_FORCE_ONE, OP_BIT_FORCE_ZERO,
                                 OP_TEST_AND_SET_BRANCH};
  assign step = is_word ? 16'h0002 : 16'h0001;
  assign rd_bit = mem_rdata[bit_pos];
  assign want = cur_op == OP_WAIT_IO_BIT_HIGH;
  assign rd_done = state == ST_READ && mem_ack;
  assign wr_done = state == ST_WRITE && mem_ack;
  assign pad_end = state == ST_PAD && elapsed + 20'h1 >= budget;
  assign more = is_str && cnt != 16'h0000 && !matched;
  assign finish = (pad_end && !more) || (rd_done && is_wait && rd_bit == want);
  assign elem_done = is_str && (is_search ? rd_done : wr_done);
  assign exec_busy = !idle;
  assign exec_done = finish;
  assign pready = 1'b1;

  // Byte values are compared in the top byte so one subtractor serves both widths
  assign cmp_a = is_word ? acc[15:0] : {acc[7:0], 8'h00};
  assign cmp_b = is_word ? mem_rdata : {mem_rdata[7:0], 8'h00};
  assign diff = {1'b0, cmp_a} - {1'b0, cmp_b};
  assign cmp_eq = diff[15:0] == 16'h0000;

  always_comb begin
    mod_byte = mem_rdata[7:0];
    mod_byte[bit_pos] = cur_op != OP_BIT_FORCE_ZERO;
  end

  always_comb begin
    next_acc_op = acc;
    case (new_op)
      OP_BYTE_SWAP: next_acc_op[15:0] = {acc[7:0], acc[15:8]};
      OP_HALF_EXCHANGE: next_acc_op = {acc[15:0], acc[31:16]};
      OP_BYTE_SIGN_EXTEND: next_acc_op[15:8] = {8{acc[7]}};
      OP_WORD_SIGN_EXTEND: next_acc_op[31:16] = {16{acc[15]}};
      OP_BYTE_ZERO_FILL: next_acc_op[15:8] = 8'h00;
      OP_WORD_ZERO_FILL: next_acc_op[31:16] = 16'h0000;
      default: next_acc_op = acc;
    endcase
  end

  // First access of a string element: copy reads the source, fill writes at once
  always_comb begin
    elem_cmd = '0;
    elem_cmd.word = is_word;
    elem_cmd.addr = is_copy ? acc[15:0] : acc[31:16];
    elem_cmd.we = is_fill;
    elem_cmd.wdata = acc[15:0];
    elem_state = is_fill ? ST_WRITE : ST_READ;
    elem_cyc = is_fill ? CYC_FILL_ELEM : CYC_STR_ELEM;
  end

  always_comb begin
    start_cmd = '0;
    start_cmd.addr = addr;
    start_cmd.io = pwdata[CMD_IO_BIT] || is_wait;
    start_state = ST_READ;
    start_budget = CYC_WAIT_MIN;
    case (new_op)
      OP_BIT_MOVE: start_budget = CYC_BIT_LOAD;
      OP_BIT_FORCE_ONE, OP_BIT_FORCE_ZERO: start_budget = CYC_BIT_RMW;
      OP_BRANCH_ON_BIT_CLEAR, OP_BRANCH_ON_BIT_SET: start_budget = CYC_BR_NOT;
      OP_TEST_AND_SET_BRANCH: start_budget = CYC_TAS_NOT;
      OP_WAIT_IO_BIT_HIGH, OP_WAIT_IO_BIT_LOW: start_budget = CYC_WAIT_MIN;
      OP_BYTE_SWAP: begin
        start_state = ST_PAD;
        start_budget = CYC_BYTE_SWAP;
      end
      OP_HALF_EXCHANGE: begin
        start_state = ST_PAD;
        start_budget = CYC_HALF_XCHG;
      end
      OP_BYTE_SIGN_EXTEND, OP_BYTE_ZERO_FILL: begin
        start_state = ST_PAD;
        start_budget = CYC_EXT_BYTE;
      end
      OP_WORD_SIGN_EXTEND, OP_WORD_ZERO_FILL: begin
        start_state = ST_PAD;
        start_budget = CYC_EXT_WORD;
      end
      default: begin
        if (cnt == 16'h0000) begin
          start_state = ST_PAD;
          start_budget = is_copy ? CYC_MOVE_ZERO
                       : (is_search ? CYC_SRCH_ZERO : CYC_FILL_BASE);
        end else begin
          start_state = elem_state;
          start_cmd = elem_cmd;
          start_budget = (is_fill ? CYC_FILL_BASE : CYC_STR_BASE) + elem_cyc;
        end
      end
    endcase
  end

  // Sequencer: every instruction except the waits is padded to its fixed length while the bus acks at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      elapsed <= 20'h0;
      budget <= 20'h0;
      mem_req <= 1'b0;
      mem_cmd <= '0;
      matched <= 1'b0;
      branch_taken <= 1'b0;
    end else begin
      if (!idle) begin
        elapsed <= elapsed + 20'h1;
      end
      unique case (state)
        ST_IDLE: begin
          if (start) begin
            elapsed <= 20'h0;
            matched <= 1'b0;
            budget <= start_budget;
            state <= start_state;
            mem_req <= start_state != ST_PAD;
            mem_cmd <= start_cmd;
          end
        end
        ST_READ: begin
          if (mem_ack) begin
            if (is_wait) begin
              if (rd_bit == want) begin
                state <= ST_IDLE;
                mem_req <= 1'b0;
              end
            end else if (is_copy) begin
              state <= ST_WRITE;
              mem_cmd.we <= 1'b1;
              mem_cmd.addr <= acc[31:16];
              mem_cmd.wdata <= mem_rdata;
            end else if (is_rmw) begin
              state <= ST_WRITE;
              mem_cmd.we <= 1'b1;
              mem_cmd.wdata <= {8'h00, mod_byte};
              if (cur_op == OP_TEST_AND_SET_BRANCH) begin
                budget <= rd_bit ? CYC_TAS_TAKEN : CYC_TAS_NOT;
                branch_taken <= rd_bit;
              end
            end else begin
              state <= ST_PAD;
              mem_req <= 1'b0;
              if (is_search && cmp_eq) begin
                matched <= 1'b1;
                budget <= budget + CYC_MATCH_EXTRA;
              end
              if (cur_op == OP_BRANCH_ON_BIT_CLEAR) begin
                budget <= !rd_bit ? CYC_BR_TAKEN : CYC_BR_NOT;
                branch_taken <= !rd_bit;
              end
              if (cur_op == OP_BRANCH_ON_BIT_SET) begin
                budget <= rd_bit ? CYC_BR_TAKEN : CYC_BR_NOT;
                branch_taken <= rd_bit;
              end
            end
          end
        end
        ST_WRITE: begin
          if (mem_ack) begin
            state <= ST_PAD;
            mem_req <= 1'b0;
          end
        end
        ST_PAD: begin
          if (pad_end) begin
            if (more) begin
              budget <= budget + elem_cyc;
              state <= elem_state;
              mem_req <= 1'b1;
              mem_cmd <= elem_cmd;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_op <= OP_BIT_MOVE;
      bit_pos <= 3'h0;
      io_sel <= 1'b0;
      start_cnt <= CNT_RST;
      last_len <= 20'h0;
    end else begin
      if (start) begin
        cur_op <= new_op;
        bit_pos <= pwdata[CMD_BIT_LSB +: 3];
        io_sel <= pwdata[CMD_IO_BIT];
        start_cnt <= cnt;
      end
      if (finish) begin
        last_len <= elapsed + 20'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr <= ADDR_RST;
    end else if (apb_wr && paddr == REG_ADDR && idle) begin
      addr <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= CNT_RST;
    end else if (elem_done) begin
      cnt <= cnt - 16'h0001;
    end else if (apb_wr && paddr == REG_CNT && idle) begin
      cnt <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= ACC_RST;
    end else if (start) begin
      acc <= next_acc_op;
    end else if (rd_done && cur_op == OP_BIT_MOVE) begin
      acc[15:0] <= {15'h0000, rd_bit};
    end else if (elem_done) begin
      // Searches and fills walk only the destination pointer
      acc[31:16] <= is_down ? acc[31:16] - step : acc[31:16] + step;
      if (is_copy) begin
        acc[15:0] <= is_down ? acc[15:0] - step : acc[15:0] + step;
      end
    end else if (apb_wr && paddr == REG_ACC && idle) begin
      acc <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= '0;
    end else if (start) begin
      case (new_op)
        OP_BYTE_SIGN_EXTEND: begin
          flags.n <= acc[7];
          flags.z <= acc[7:0] == 8'h00;
        end
        OP_WORD_SIGN_EXTEND: begin
          flags.n <= acc[15];
          flags.z <= acc[15:0] == 16'h0000;
        end
        OP_BYTE_ZERO_FILL: begin
          flags.n <= 1'b0;
          flags.z <= acc[7:0] == 8'h00;
        end
        OP_WORD_ZERO_FILL: begin
          flags.n <= 1'b0;
          flags.z <= acc[15:0] == 16'h0000;
        end
        OP_BYTE_BLOCK_FILL, OP_WORD_BLOCK_FILL: begin
          flags.n <= cmp_a[15];
          flags.z <= cmp_a == 16'h0000;
        end
        default: flags <= flags;
      endcase
    end else if (rd_done && cur_op == OP_BIT_MOVE) begin
      flags.n <= 1'b0;
      flags.z <= !rd_bit;
    end else if (rd_done && cur_op inside {OP_BRANCH_ON_BIT_CLEAR, OP_BRANCH_ON_BIT_SET,
                                           OP_TEST_AND_SET_BRANCH}) begin
      flags.z <= !rd_bit;
    end else if (elem_done && is_search) begin
      flags.n <= diff[15];
      flags.z <= cmp_eq;
      flags.c <= diff[16];
      flags.v <= (cmp_a[15] ^ cmp_b[15]) & (cmp_a[15] ^ diff[15]);
    end else if (apb_wr && paddr == REG_FLAGS && idle) begin
      flags <= pwdata[3:0];
    end
  end

  always_comb begin
    rd_bad = 1'b0;
    rd_mux = 32'h0000_0000;
    case (paddr)
      REG_CMD: rd_mux = {23'h0, io_sel, bit_pos, cur_op};
      REG_ADDR: rd_mux = {16'h0000, addr};
      REG_ACC: rd_mux = acc;
      REG_CNT: rd_mux = {16'h0000, cnt};
      REG_FLAGS: rd_mux = {28'h0, flags};
      REG_STAT: rd_mux = {29'h0, matched, branch_taken, !idle};
      REG_LEN: rd_mux = {12'h000, last_len};
      default: rd_bad = 1'b1;
    endcase
  end

  // Answer is prepared in the setup phase so read data leaves a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr <= rd_bad || (pwrite && paddr == REG_CMD && pwdata[CMD_OP_LSB +: 5] > OP_LAST);
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [19:0] move_len;
  logic [19:0] fill_len;
  assign move_len = start_cnt == 16'h0000 ? CYC_MOVE_ZERO
                  : CYC_STR_BASE + 20'(start_cnt) * CYC_STR_ELEM;
  assign fill_len = CYC_FILL_BASE + 20'(start_cnt) * CYC_FILL_ELEM;

  sequence s_rmw_read;
    rd_done && cur_op inside {OP_BIT_FORCE_ONE, OP_BIT_FORCE_ZERO};
  endsequence
  sequence s_rmw_write;
    state == ST_WRITE && mem_req && mem_cmd.we
      && mem_cmd.wdata[bit_pos] == (cur_op == OP_BIT_FORCE_ONE);
  endsequence

  a_load_len:
    assert property (finish && cur_op == OP_BIT_MOVE |-> elapsed == 20'h2)
    else $error("Bit load did not take three cycles");
  a_load_value:
    assert property (finish && cur_op == OP_BIT_MOVE |-> acc[15:1] == 15'h0 && flags.z == !acc[0])
    else $error("Bit load result or zero flag wrong");
  a_rmw_write:
    assert property (s_rmw_read |=> s_rmw_write)
    else $error("Set or clear bit did not write the forced value");
  a_rmw_len:
    assert property (finish && cur_op inside {OP_BIT_FORCE_ONE, OP_BIT_FORCE_ZERO}
                     |-> elapsed == 20'h3 && $stable(flags))
    else $error("Set or clear bit length or flags wrong");
  a_branch_len:
    assert property (finish && cur_op inside {OP_BRANCH_ON_BIT_CLEAR, OP_BRANCH_ON_BIT_SET}
                     |-> elapsed == (branch_taken ? 20'h4 : 20'h3))
    else $error("Bit branch length wrong");
  a_branch_sense:
    assert property (finish && cur_op inside {OP_BRANCH_ON_BIT_CLEAR, OP_BRANCH_ON_BIT_SET}
                     |-> branch_taken == (flags.z == (cur_op == OP_BRANCH_ON_BIT_CLEAR)))
    else $error("Bit branch taken on wrong bit value");
  a_tas_len:
    assert property (finish && cur_op == OP_TEST_AND_SET_BRANCH
                     |-> elapsed == (branch_taken ? 20'h6 : 20'h5))
    else $error("Test-and-set length wrong");
  a_wait_again:
    assert property (rd_done && is_wait && rd_bit != want |=> state == ST_READ && mem_req)
    else $error("Wait stopped before the bit reached its level");
  a_wait_flags:
    assert property (exec_busy && is_wait |=> $stable(flags))
    else $error("Wait changed a flag");
  a_swap_len:
    assert property (finish && cur_op == OP_BYTE_SWAP |-> elapsed == 20'h2 && $stable(flags))
    else $error("Byte swap length or flags wrong");
  a_move_len:
    assert property (finish && is_copy |-> elapsed + 20'h1 == move_len)
    else $error("String move length wrong");
  a_fill_len:
    assert property (finish && is_fill |-> elapsed + 20'h1 == fill_len)
    else $error("Fill length wrong");
  a_count_step:
    assert property (elem_done |=> cnt == $past(cnt) - 16'h0001)
    else $error("Count did not step by one per element");
endmodule

/* File: verification/bsaeu_mem_model.sv */
// Memory and I/O space model on the executor's access port
module bsaeu_mem_model
  import bsaeu_pkg::*;
(
  input wire logic pclk, // Core clock
  input wire logic presetn, // Reset, active low
  input wire logic mem_req, // Access request
  input wire bsaeu_mem_s mem_cmd, // Access fields
  output logic mem_ack, // Access done
  output logic [15:0] mem_rdata, // Read data
  input wire logic slow // Ack accesses only on every other cycle
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [7:0] io_mem [256];
  logic [7:0] a;
  logic tick;
  assign a = mem_cmd.addr[7:0];
  // Slow mode acks every other cycle, so the request must be held meanwhile
  assign mem_ack = mem_req & (!slow | tick);
  // Outside an ack the data wander, so a stale sample cannot pass
  assign mem_rdata = !mem_ack ? {a, ~a} ^ {16{tick}} :
    mem_cmd.io ? {8'h00, io_mem[a]} : {mem[a + 8'h01], mem[a]};
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = i[7:0];
      io_mem[i] = 8'h00;
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) tick <= 1'b0;
    else tick <= ~tick;
  end
  always @(posedge pclk) begin
    if (mem_req && mem_ack && mem_cmd.we) begin
      if (mem_cmd.io) io_mem[a] <= mem_cmd.wdata[7:0];
      else mem[a] <= mem_cmd.wdata[7:0];
      if (mem_cmd.word && !mem_cmd.io) mem[a + 8'h01] <= mem_cmd.wdata[15:8];
    end
  end
endmodule

/* File: verification/bsaeu_core_tb.sv */
// Self-checking bench for the bit, accumulator and string executor
module bsaeu_core_tb import bsaeu_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic pready, pslverr, mem_req, mem_ack, exec_busy, exec_done, branch_taken, err;
  bsaeu_mem_s mem_cmd;
  logic [15:0] mem_rdata;
  int fails = 0, check_count = 0, cyc = 0, n, dones = 0;
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) if (exec_busy === 1'b1) cyc <= cyc + 1;
  always @(posedge pclk) if (exec_done === 1'b1) dones <= dones + 1;
  bsaeu_core u_bsaeu_core (.*);
  bsaeu_mem_model u_mem (.*);
  task automatic chk(input logic [31:0] g, e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  // Busy cycles are counted on the clock; slow acks that fit in the padding add none
  task automatic go(input logic [31:0] c);
    int s;
    int d;
    s = cyc;
    d = dones;
    wr(REG_CMD, c);
    do @(negedge pclk); while (exec_busy !== 1'b0);
    n = cyc - s;
    chk(dones - d, 32'h1);
  endtask
  task automatic t_bits();
    wr(REG_ADDR, 32'h20);
    wr(REG_ACC, 32'hFFFF_FFFF);
    wr(REG_FLAGS, 32'hF);
    go(32'hA0);
    chk(n, 3);
    apb(1'b0, REG_ACC, 32'h0);
    chk(rv & 32'hFFFF, 32'h1);
    go(32'h1);
    chk(n, 4);
    chk(32'(u_mem.mem[8'h20]), 32'h21);
    go(32'hA2);
    chk(n, 4);
    chk(32'(u_mem.mem[8'h20]), 32'h01);
    apb(1'b0, REG_FLAGS, 32'h0);
    chk(rv & 32'hF, 32'h3);
  endtask
  task automatic t_branch();
    logic [31:0] c[4] = '{32'h23, 32'h24, 32'h25, 32'h25};
    int e[4] = '{5, 4, 6, 7};
    for (int i = 0; i < 4; i++) begin
      go(c[i]);
      chk(n, e[i]);
      chk(32'(branch_taken), 32'(e[i] & 1));
    end
    chk(32'(u_mem.mem[8'h20]), 32'h03);
    apb(1'b0, REG_FLAGS, 32'h0);
    chk(rv & 32'h4, 32'h0);
  endtask
  task automatic t_wait();
    for (int i = 0; i < 2; i++) begin
      fork
        go(32'h106 + i);
        begin
          repeat (14) @(posedge pclk);
          u_mem.io_mem[8'h20] <= 8'(1 - i);
        end
      join
      chk(32'(n > 10), 32'h1);
    end
  endtask
  task automatic t_acc();
    logic [31:0] a[6] = '{32'h1234_8081, 32'h1234_8081, 32'h1234_5680, 32'h1234_8000,
      32'h1234_56F0, 32'h1234_0000};
    logic [31:0] x[6] = '{32'h1234_8180, 32'h8081_1234, 32'hFF80, 32'hFFFF_8000, 32'hF0, 32'h0};
    logic [31:0] m[6] = '{'1, '1, 32'hFFFF, '1, 32'hFFFF, '1};
    int e[6] = '{3, 2, 1, 2, 1, 2};
    logic [31:0] f[6] = '{32'hF, 32'hF, 32'hB, 32'hB, 32'h3, 32'h7};
    for (int i = 0; i < 6; i++) begin
      wr(REG_ACC, a[i]);
      wr(REG_FLAGS, 32'hF);
      go(32'h8 + i);
      chk(n, e[i]);
      apb(1'b0, REG_ACC, 32'h0);
      chk(rv & m[i], x[i]);
      apb(1'b0, REG_FLAGS, 32'h0);
      chk(rv & 32'hF, f[i]);
    end
  endtask
  task automatic t_copy();
    wr(REG_ACC, 32'h0060_0040);
    wr(REG_CNT, 32'h2);
    go(32'h10);
    chk(n, 14);
    chk(32'(u_mem.mem[8'h62]), 32'h42);
    apb(1'b0, REG_ACC, 32'h0);
    chk(rv, 32'h0064_0044);
    apb(1'b0, REG_CNT, 32'h0);
    chk(rv, 32'h0);
    apb(1'b0, REG_LEN, 32'h0);
    chk(rv, 32'd14);
    slow <= 1'b1;
    wr(REG_ACC, 32'h0073_0013);
    wr(REG_CNT, 32'h3);
    go(32'hF);
    slow <= 1'b0;
    chk(n, 20);
    chk(32'(u_mem.mem[8'h71]), 32'h11);
    apb(1'b0, REG_ACC, 32'h0);
    chk(rv, 32'h0070_0010);
    wr(REG_ACC, 32'h00B0_0005);
    wr(REG_CNT, 32'h1);
    go(32'hE);
    chk(n, 8);
    chk(32'(u_mem.mem[8'hB0]), 32'h05);
  endtask
  task automatic t_search_fill();
    wr(REG_ACC, 32'h0040_4342);
    wr(REG_CNT, 32'h3);
    go(32'h14);
    chk(n, 16);
    apb(1'b0, REG_FLAGS, 32'h0);
    chk(rv & 32'hF, 32'h4);
    apb(1'b0, REG_CNT, 32'h0);
    chk(rv, 32'h1);
    apb(1'b0, REG_STAT, 32'h0);
    chk(rv & 32'h5, 32'h4);
    wr(REG_CNT, 32'h0);
    go(32'h14);
    chk(n, 3);
    wr(REG_ACC, 32'h0050_0052);
    wr(REG_CNT, 32'h3);
    go(32'h12);
    chk(n, 22);
    wr(REG_CNT, 32'h2);
    go(32'h13);
    chk(n, 16);
    apb(1'b0, REG_ACC, 32'h0);
    chk(rv, 32'h0051_0052);
    wr(REG_ACC, 32'h00C0_0000);
    wr(REG_CNT, 32'h1);
    go(32'h16);
    chk(n, 8);
    chk(32'({u_mem.mem[8'hC1], u_mem.mem[8'hC0]}), 32'hC100);
    apb(1'b0, REG_FLAGS, 32'h0);
    chk(rv & 32'hC, 32'h4);
    wr(REG_ACC, 32'h00A0_8001);
    wr(REG_CNT, 32'h2);
    go(32'h17);
    chk(n, 13);
    chk(32'(u_mem.mem[8'hA3]), 32'h80);
    apb(1'b0, REG_FLAGS, 32'h0);
    chk(rv & 32'hC, 32'h8);
    apb(1'b0, 8'h40, 32'h0);
    chk(32'(err), 32'h1);
  endtask
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    final_report();
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_bits();
    t_branch();
    t_wait();
    t_acc();
    t_copy();
    t_search_fill();
    final_report();
  end
endmodule
